/* File: hdl/shrc_standby.sv */
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`default_nettype none
module shrc_standby
  import shrc_pkg::*;
#(
  parameter int WUP_N1 = 256,    // warm-up ticks, code 01
  parameter int WUP_N2 = 16384,  // warm-up ticks, code 10
  parameter int WUP_N3 = 65536   // warm-up ticks, code 11
)(
  input  wire logic              hclk,           // system clock
  input  wire logic              hresetn,        // async reset, low
  input  wire logic              hsel,           // slave select
  input  wire logic [7:0]        haddr,          // byte address
  input  wire logic [1:0]        htrans,         // transfer type
  input  wire logic              hwrite,         // write strobe
  input  wire logic [2:0]        hsize,          // word only
  input  wire logic [31:0]       hwdata,         // write data
  input  wire logic              hready,         // bus ready
  output logic [31:0]            hrdata,         // read data
  output logic                   hreadyout,      // always ready
  output logic                   hresp,          // always okay
  input  wire logic              halt_exec,      // halt instruction pulse
  input  wire logic [NSRC-1:0]   irq_req,        // request per source
  input  wire logic [3*NSRC-1:0] irq_level,      // level per source
  input  wire logic [2:0]        interrupt_mask_level, // cpu mask
  input  wire logic              osc_high_tick,  // high oscillator tick
  input  wire logic              osc_low_tick,   // low oscillator tick
  output logic                   cpu_run,        // cpu executes
  output logic                   sys_clk_en,     // system clock gate
  output logic                   osc_high_run,   // high oscillator on
  output logic                   osc_low_run,    // low oscillator on
  output logic                   clk_low_mode,   // system on low clock
  output logic [5:0]             periph_run,     // peripheral run enables
  output logic                   rtc_mld_run,    // tick and melody run
  output logic                   pin_drive_select, // pin state select
  output logic                   pin_drive_enable, // pin drive on
  output logic                   service_req,    // start servicing pulse
  output logic                   resume_req,     // resume after halt pulse
  output logic                   flag_clear,     // clear source flag pulse
  output logic [3:0]             release_src     // releasing source
);
  typedef enum logic [2:0] {ST_RUN, ST_PERIPHERAL_IDLE_MODE, ST_OSCILLATOR_ONLY_IDLE_MODE, ST_STOP, ST_WARM} shrc_state_type;
  shrc_state_type state;
  shrc_state_type next_state;
  shrc_ctrl_type  ctrl;
  shrc_wake_type  wake;
  shrc_wake_type  held;
  logic [7:0]     wr_addr;
  logic           wr_pend;
  logic           warm_done;
  logic           release_now;
  logic [1:0]     kind_now;
  logic           addr_ok;
  logic [31:0]    rd_value;
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign rd_value = (haddr == ADDR_CTRL)   ? {17'h0, ctrl} :
                    (haddr == ADDR_STATUS) ? {23'h0, held.service, held.src,
                                              clk_low_mode, 3'(state)} : 32'h0;
  // address phase latch, read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= haddr;
      if (addr_ok & !hwrite)
        hrdata <= rd_value;
    end
  end
  // control register write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl <= CTRL_RESET;
    else if (wr_pend & (wr_addr == ADDR_CTRL))
      ctrl <= hwdata[14:0];
  end
  // ----------------------------------------------------------------
  // release decision and warm-up
  // ----------------------------------------------------------------
  assign kind_now = (state == ST_PERIPHERAL_IDLE_MODE) ? HK_PERIPHERAL_IDLE_MODE :
                    (state == ST_OSCILLATOR_ONLY_IDLE_MODE) ? HK_OSCILLATOR_ONLY_IDLE_MODE :
                    (state == ST_STOP)  ? HK_STOP  : HK_NONE;
  shrc_release_decode u_dec (
    .req   (irq_req),
    .level (irq_level),
    .mask  (interrupt_mask_level),
    .kind  (kind_now),
    .wake  (wake)
  );
  shrc_warmup #(
    .WUP_N1 (WUP_N1),
    .WUP_N2 (WUP_N2),
    .WUP_N3 (WUP_N3)
  ) u_wup (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   ((state == ST_STOP) & wake.wake),
    .tick    (ctrl.clk_sel_low ? osc_low_tick : osc_high_tick),
    .sel     (ctrl.warmup_length_select),
    .done    (warm_done)
  );
  // idle wakes at once, stop only after warm-up
  assign release_now = ((state == ST_PERIPHERAL_IDLE_MODE) | (state == ST_OSCILLATOR_ONLY_IDLE_MODE)) & wake.wake |
                       (state == ST_WARM) & warm_done;
  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (halt_exec)
        begin
          case (ctrl.halt_kind_select)
            HK_PERIPHERAL_IDLE_MODE: next_state = ST_PERIPHERAL_IDLE_MODE;
            HK_OSCILLATOR_ONLY_IDLE_MODE: next_state = ST_OSCILLATOR_ONLY_IDLE_MODE;
            HK_STOP:  next_state = ST_STOP;
            default:  next_state = ST_RUN;
          endcase
        end
      ST_PERIPHERAL_IDLE_MODE, ST_OSCILLATOR_ONLY_IDLE_MODE:
        if (wake.wake)
          next_state = ST_RUN;
      ST_STOP:
        if (wake.wake)
          next_state = ST_WARM;
      ST_WARM:
        if (warm_done)
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ST_RUN;
      held  <= '0;
    end
    else
    begin
      state <= next_state;
      if (wake.wake & (state != ST_RUN) & (state != ST_WARM))
        held <= wake;
    end
  end
  // ----------------------------------------------------------------
  // release pulses
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      service_req <= 1'b0;
      resume_req  <= 1'b0;
      flag_clear  <= 1'b0;
      release_src <= '0;
    end
    else
    begin
      service_req <= release_now & ((state == ST_WARM) ? held.service : wake.service);
      resume_req  <= release_now & !((state == ST_WARM) ? held.service : wake.service);
      // flag stays set on a resume release
      flag_clear  <= release_now & ((state == ST_WARM) ? held.service : wake.service);
      if (release_now)
        release_src <= (state == ST_WARM) ? held.src : wake.src;
    end
  end
  // ----------------------------------------------------------------
  // clock, oscillator and pin control
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_run          <= 1'b1;
      sys_clk_en       <= 1'b1;
      osc_high_run     <= 1'b1;
      osc_low_run      <= 1'b0;
      clk_low_mode     <= 1'b0;
      periph_run       <= '1;
      rtc_mld_run      <= 1'b1;
      pin_drive_select <= 1'b0;
      pin_drive_enable <= 1'b0;
    end
    else
    begin
      cpu_run     <= next_state == ST_RUN;
      sys_clk_en  <= (next_state == ST_RUN) | (next_state == ST_PERIPHERAL_IDLE_MODE);
      periph_run  <= (next_state == ST_RUN) ? 6'h3f :
                     (next_state == ST_PERIPHERAL_IDLE_MODE) ? ctrl.idle_run : 6'h00;
      rtc_mld_run <= (next_state != ST_STOP) & (next_state != ST_WARM);
      // oscillators off in stop, chosen one restarts for warm-up
      if (next_state == ST_STOP)
      begin
        osc_high_run <= 1'b0;
        osc_low_run  <= 1'b0;
      end
      else if (next_state == ST_WARM)
      begin
        osc_high_run <= ctrl.high_osc_enable_after_release | !ctrl.clk_sel_low;
        osc_low_run  <= ctrl.low_osc_enable_after_release | ctrl.clk_sel_low;
      end
      if ((state == ST_WARM) & warm_done)
        clk_low_mode <= ctrl.clk_sel_low;
      pin_drive_select <= (next_state == ST_OSCILLATOR_ONLY_IDLE_MODE) & ctrl.pin_drive_select;
      pin_drive_enable <= ((next_state == ST_OSCILLATOR_ONLY_IDLE_MODE) | (next_state == ST_STOP) | (next_state == ST_WARM))
                          & ctrl.pin_drive_enable;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_MODE_ENTRY: assert property ((state == ST_RUN) & halt_exec & (ctrl.halt_kind_select == HK_STOP)
    |=> state == ST_STOP) else $error("stop not entered");
  AST_SERVICE: assert property ((state == ST_PERIPHERAL_IDLE_MODE) & wake.wake & wake.service
    |=> service_req & flag_clear & !resume_req) else $error("no servicing");
  AST_RESUME: assert property ((state == ST_OSCILLATOR_ONLY_IDLE_MODE) & wake.wake & !wake.service
    |=> resume_req & !service_req) else $error("no resume");
  AST_FLAG_KEPT: assert property (resume_req |-> !flag_clear) else $error("flag cleared");
  AST_STOP_SRC: assert property ((state == ST_STOP) ##1 (state == ST_WARM)
    |-> GRP_ANY[$past(wake.src)]) else $error("bad stop source");
  AST_OSCILLATOR_ONLY_IDLE_MODE_HOLD: assert property ((state == ST_OSCILLATOR_ONLY_IDLE_MODE) & ((irq_req & (GRP_ANY | GRP_IDLE)) == '0)
    |=> state == ST_OSCILLATOR_ONLY_IDLE_MODE) else $error("oscillator_only_idle_mode left");
  AST_WDT_LEVEL: assert property ((state == ST_PERIPHERAL_IDLE_MODE) & irq_req[SRC_WDT] & (irq_req[11:1] == '0)
    |=> service_req) else $error("watchdog not serviced");
  AST_WARM_WAIT: assert property ((state == ST_STOP) & wake.wake
    |=> !cpu_run [*2]) else $error("stop released early");
  AST_PERIPHERAL_IDLE_MODE_PERIPH: assert property ((state == ST_PERIPHERAL_IDLE_MODE) & $stable(ctrl)
    |-> !cpu_run & (periph_run == ctrl.idle_run)) else $error("peripheral_idle_mode outputs");
  AST_STOP_OSC: assert property ((state == ST_STOP) |-> !osc_high_run & !osc_low_run & !sys_clk_en)
    else $error("stop clocks running");
  COV_PERIPHERAL_IDLE_MODE: cover property ((state == ST_PERIPHERAL_IDLE_MODE) ##1 service_req);
  COV_OSCILLATOR_ONLY_IDLE_MODE: cover property ((state == ST_OSCILLATOR_ONLY_IDLE_MODE) ##1 resume_req);
  COV_STOP: cover property ((state == ST_WARM) ##[1:300] (state == ST_RUN));
endmodule : shrc_standby
`default_nettype wire

/* File: hdl/shrc_pkg.sv */
`default_nettype none
package shrc_pkg;
  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  // halt kind codes
  localparam logic [1:0] HK_NONE  = 2'h0;
  localparam logic [1:0] HK_STOP  = 2'h1;
  localparam logic [1:0] HK_OSCILLATOR_ONLY_IDLE_MODE = 2'h2;
  localparam logic [1:0] HK_PERIPHERAL_IDLE_MODE = 2'h3;
  // warm-up length codes
  localparam logic [1:0] WUP_SHORT = 2'h1;
  localparam logic [1:0] WUP_MID   = 2'h2;
  localparam logic [1:0] WUP_LONG  = 2'h3;
  // --------------------------------------------------------------
  // interrupt sources
  // --------------------------------------------------------------
  localparam int NSRC = 12;
  localparam int SRC_WDT = 0;
  localparam logic [2:0] WDT_LEVEL = 3'h7;
  // ext0..3 (1..4), key (8): release every mode, any level
  localparam logic [NSRC-1:0] GRP_ANY  = 12'h11e;
  // alarm (5), realtime tick (6): release idle modes, any level
  localparam logic [NSRC-1:0] GRP_IDLE = 12'h060;
  // timer 7, serial 9, converter 10, display 11: peripheral_idle_mode only
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // control register layout, reset value
  typedef struct packed {
    logic [5:0] idle_run;
    logic       pin_drive_enable;
    logic       pin_drive_select;
    logic       low_osc_enable_after_release;
    logic       high_osc_enable_after_release;
    logic       clk_sel_low;
    logic [1:0] warmup_length_select;
    logic [1:0] halt_kind_select;
  } shrc_ctrl_type;
  localparam logic [14:0] CTRL_RESET = 15'h0059;
  // release decision handed to the sequencer
  typedef struct packed {
    logic       wake;
    logic       service;
    logic [3:0] src;
  } shrc_wake_type;
endpackage : shrc_pkg
`default_nettype wire

/* File: hdl/shrc_release_decode.sv */
`default_nettype none
module shrc_release_decode
  import shrc_pkg::*;
(
  input  wire logic [NSRC-1:0]   req,       // raw request levels
  input  wire logic [3*NSRC-1:0] level,     // request level per source
  input  wire logic [2:0]        mask,      // current mask level
  input  wire logic [1:0]        kind,      // active halt kind
  output shrc_wake_type          wake       // combined decision
);
  logic [NSRC-1:0] en;
  logic [NSRC-1:0] rel;
  // ----------------------------------------------------------------
  // per source enable and release capability
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NSRC; i++)
    begin : g_src
      wire logic [2:0] lv = (i == SRC_WDT) ? WDT_LEVEL : level[3*i +: 3];
      assign en[i] = lv >= mask;
      // peripheral_idle_mode also releases on enabled source; oscillator_only_idle_mode and stop never do
      assign rel[i] = req[i] & ((kind == HK_PERIPHERAL_IDLE_MODE) ? (en[i] | GRP_ANY[i] | GRP_IDLE[i]) :
                                (kind == HK_OSCILLATOR_ONLY_IDLE_MODE) ? (GRP_ANY[i] | GRP_IDLE[i]) :
                                (kind == HK_STOP)  ? GRP_ANY[i] : 1'b0);
    end
  endgenerate
  // lowest index wins
  always_comb
  begin
    wake = '0;
    for (int k = NSRC - 1; k >= 0; k--)
    begin
      if (rel[k])
      begin
        wake.wake    = 1'b1;
        wake.service = en[k];
        wake.src     = 4'(k);
      end
    end
  end
endmodule : shrc_release_decode
`default_nettype wire

/* File: hdl/shrc_warmup.sv */
`default_nettype none
module shrc_warmup
  import shrc_pkg::*;
#(
  parameter int WUP_N1 = 256,    // ticks for code 01
  parameter int WUP_N2 = 16384,  // ticks for code 10
  parameter int WUP_N3 = 65536   // ticks for code 11
)(
  input  wire logic       hclk,    // system clock
  input  wire logic       hresetn, // async reset, low
  input  wire logic       start,   // begin counting
  input  wire logic       tick,    // selected oscillator tick
  input  wire logic [1:0] sel,     // warm-up length code
  output logic            done     // terminal count pulse
);
  logic [16:0] cnt;
  logic [16:0] limit;
  logic        busy;
  // length per code, code 00 treated as shortest
  assign limit = (sel == WUP_MID)  ? 17'(WUP_N2 - 1) :
                 (sel == WUP_LONG) ? 17'(WUP_N3 - 1) : 17'(WUP_N1 - 1);
  // counter advances on oscillator ticks only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= busy & tick & (cnt == limit);
      if (start)
      begin
        cnt  <= '0;
        busy <= 1'b1;
      end
      else if (busy & tick)
      begin
        cnt  <= cnt + 17'h1;
        busy <= cnt != limit;
      end
    end
  end
endmodule : shrc_warmup
`default_nettype wire

/* File: tb/shrc_cpu_model.sv */
`default_nettype none
module shrc_cpu_model
  import shrc_pkg::*;
(
  input  wire logic           hclk,          // system clock
  input  wire logic           hresetn,       // async reset, low
  input  wire logic           raise,         // start a request
  input  wire logic [3:0]     src,           // requesting source
  input  wire logic [2:0]     lvl,           // request level
  input  wire logic           service_req,   // servicing started
  input  wire logic           resume_req,    // resumed after halt
  input  wire logic           osc_high_run,  // high oscillator on
  input  wire logic           osc_low_run,   // low oscillator on
  output logic [NSRC-1:0]     irq_req,       // held requests
  output logic [3*NSRC-1:0]   irq_level,     // request levels
  output logic                osc_high_tick, // high oscillator tick
  output logic                osc_low_tick   // low oscillator tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div; // oscillator divider
  // requests stay up until the cpu takes them, ticks only while running
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_req       <= '0;
      irq_level     <= '0;
      div           <= 2'h0;
      osc_high_tick <= 1'b0;
      osc_low_tick  <= 1'b0;
    end
    else
    begin
      div           <= div + 2'h1;
      osc_high_tick <= osc_high_run & div[0];
      osc_low_tick  <= osc_low_run & (div == 2'h3);
      if (raise)
      begin
        irq_req[src] <= 1'b1;
        irq_level    <= {NSRC{lvl}};
      end
      else if (service_req | resume_req)
        irq_req <= '0;
    end
  end
endmodule : shrc_cpu_model
`default_nettype wire

/* File: tb/standby_halt_release_control_test.sv */
`default_nettype none
module standby_halt_release_control_test
  import shrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  int n_errors = 0;
  int n_checks = 0;
  logic hclk, hresetn, hsel, hwrite, hready, halt_exec, raise;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, mask, lvl;
  logic [31:0] hwdata, hrdata, r;
  logic hreadyout, hresp, cpu_run, sys_clk_en, osc_high_run, osc_low_run, clk_low_mode;
  logic rtc_mld_run, pin_drive_select, pin_drive_enable, service_req, resume_req, flag_clear;
  logic osc_high_tick, osc_low_tick;
  logic [5:0] periph_run;
  logic [3:0] release_src, src;
  logic [NSRC-1:0] irq_req;
  logic [3*NSRC-1:0] irq_level;
  logic [1:0] kinds [3] = '{HK_PERIPHERAL_IDLE_MODE, HK_OSCILLATOR_ONLY_IDLE_MODE, HK_STOP};
  int cyc, leak;
  assign hready = hreadyout;
  shrc_standby #(.WUP_N1(4), .WUP_N2(8), .WUP_N3(16)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .halt_exec(halt_exec), .irq_req(irq_req),
    .irq_level(irq_level), .interrupt_mask_level(mask), .osc_high_tick(osc_high_tick),
    .osc_low_tick(osc_low_tick), .cpu_run(cpu_run), .sys_clk_en(sys_clk_en), .osc_high_run(osc_high_run),
    .osc_low_run(osc_low_run), .clk_low_mode(clk_low_mode), .periph_run(periph_run),
    .rtc_mld_run(rtc_mld_run), .pin_drive_select(pin_drive_select), .pin_drive_enable(pin_drive_enable),
    .service_req(service_req), .resume_req(resume_req), .flag_clear(flag_clear),
    .release_src(release_src));
  shrc_cpu_model i_cpu (.hclk(hclk), .hresetn(hresetn), .raise(raise), .src(src), .lvl(lvl),
    .service_req(service_req), .resume_req(resume_req), .osc_high_run(osc_high_run),
    .osc_low_run(osc_low_run), .irq_req(irq_req), .irq_level(irq_level), .osc_high_tick(osc_high_tick),
    .osc_low_tick(osc_low_tick));
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic do_reset(input int n);
    hresetn <= 1'b0;
    repeat (n) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset
  // program control then execute halt
  task automatic halt_with(input logic [31:0] ctrl);
    logic [31:0] d;
    bus(1'b1, ADDR_CTRL, ctrl, d);
    halt_exec <= 1'b1;
    @(posedge hclk);
    halt_exec <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : halt_with
  // raise a request and wait for a release pulse
  task automatic req_wait(input logic [3:0] s, input logic [2:0] l);
    src   <= s;
    lvl   <= l;
    raise <= 1'b1;
    @(posedge hclk);
    raise <= 1'b0;
    cyc  = 0;
    leak = 0;
    do
    begin
      @(posedge hclk);
      cyc++;
      if (service_req !== 1'b1 && resume_req !== 1'b1 && sys_clk_en !== 1'b0)
        leak++;
    end
    while (service_req !== 1'b1 && resume_req !== 1'b1 && cyc < 300);
  endtask : req_wait
  // 0 stays halted, 1 resume, 2 service
  function automatic int rel_kind(input int s, input logic [1:0] k, input bit en);
    if (s == 0)
      return (k == HK_PERIPHERAL_IDLE_MODE) ? 2 : 0;
    if (s inside {1, 2, 3, 4, 8} || (s inside {5, 6} && k != HK_STOP))
      return en ? 2 : 1;
    return (k == HK_PERIPHERAL_IDLE_MODE && en) ? 2 : 0;
  endfunction : rel_kind
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // --------------------------------------------------------------
  // stimulus
  // --------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // watchdog against a hang
  initial
  begin
    #10000000;
    n_errors++;
    end_sim();
  end
  // main sequence
  initial
  begin
    {hsel, hwrite, halt_exec, raise, haddr, htrans, hwdata, src, lvl} = '0;
    hsize   = 3'h2;
    mask    = 3'h4;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, ADDR_CTRL, '0, r);
    check("ctrl_reset", r, {17'h0, CTRL_RESET});
    bus(1'b0, ADDR_STATUS, '0, r);
    check("status_reset", r, 32'h0);
    check("hresp_okay", hresp, 32'h0);
    check("hreadyout", hreadyout, 32'h1);
    bus(1'b1, 8'h08, 32'hffffffff, r);
    bus(1'b0, 8'h08, '0, r);
    check("unmapped", r, 32'h0);
    halt_with(32'h000055a4);
    check("kind_none", cpu_run, 1);
    for (int k = 0; k < 3; k++)
      for (int s = 0; s < NSRC; s++)
        for (int e = 0; e < 2; e++)
        begin
          halt_with(32'h000055a4 | kinds[k]);
          bus(1'b0, ADDR_STATUS, '0, r);
          check("state", r[2:0], 3'h4 - {1'b0, kinds[k]});
          check("cpu_stop", cpu_run, 0);
          check("periph", periph_run, (kinds[k] == HK_PERIPHERAL_IDLE_MODE) ? 6'h2a : 6'h00);
          check("sys_clk", sys_clk_en, kinds[k] == HK_PERIPHERAL_IDLE_MODE);
          check("rtc_run", rtc_mld_run, kinds[k] != HK_STOP);
          check("osc_run", osc_high_run, kinds[k] != HK_STOP);
          check("drv_sel", pin_drive_select, kinds[k] == HK_OSCILLATOR_ONLY_IDLE_MODE);
          check("drv_en", pin_drive_enable, kinds[k] != HK_PERIPHERAL_IDLE_MODE);
          req_wait(s[3:0], e ? 3'h4 : 3'h3);
          if (rel_kind(s, kinds[k], e) == 0)
          begin
            check("no_release", cpu_run, 0);
            do_reset(2);
          end
          else
          begin
            check("service", service_req, rel_kind(s, kinds[k], e) == 2);
            check("resume", resume_req, rel_kind(s, kinds[k], e) == 1);
            check("flag_clear", flag_clear, rel_kind(s, kinds[k], e) == 2);
            check("src", release_src, s);
            check("cpu_run", cpu_run, 1);
          end
        end
    for (int c = 1; c < 4; c++)
      for (int sl = 0; sl < 2; sl++)
      begin
        halt_with(32'h00000060 | (sl << 4) | (c << 2) | HK_STOP);
        req_wait(4'h1, 3'h4);
        check("warm_len", cyc >= ((2 << c) - 1) * (sl ? 4 : 2) && cyc <= (2 << c) * (sl ? 4 : 2) + 8, 1);
        check("warm_clk_off", leak, 0);
        check("warm_serv", service_req, 1);
        check("post_clk", clk_low_mode, sl);
        check("osc_low_on", osc_low_run, 32'h1);
      end
    end_sim();
  end
endmodule : standby_halt_release_control_test
`default_nettype wire
